// ### hw/otfm_top.v
`timescale 1ns/1ps
`default_nettype none
`include "otfm_regs.vh"

// Operation
// RULE_01: Four terminals, own selector, shared table
// RULE_02: Code 0 keeps terminal inactive
// RULE_03: Code 1 on while running
// RULE_04: Code 2 on at fault stop
// RULE_05: Code 5 running at zero frequency
// RULE_06: Code 6 motor overload pre-alarm
// RULE_07: Code 7 drive overload pre-alarm
// RULE_08: Code 8 set count reached
// RULE_09: Code 9 designated count reached
// RULE_10: Code 10 length exceeded
// RULE_11: Code 11 250ms pulse per cycle
// RULE_12: Code 12 running time exceeded
// RULE_13: Code 13 frequency limited
// RULE_14: Code 14 torque limited in speed mode; code also requires st_stall_active
// RULE_15: Code 15 ready: supplies ok, no fault; code also requires st_operable
// RULE_16: Code 16 first analog above second
// RULE_17: Code 17 upper limit reached
// RULE_18: Code 18 lower limit, off when stopped
// RULE_19: Code 19 undervoltage
// RULE_20: Code 23 zero frequency or stopped
// RULE_21: Code 24 power-on time exceeded
// RULE_22: Selector reset values 1, 2, 0, 0
// RULE_23: Switch selector used only in switch mode
// RULE_24: Synchronous level inputs, update every clock
// RULE_25: Codes 3,4,20,25 pass through; reserved off
module otfm_top #(
  parameter PULSE_CYC = `OTFM_PULSE_CYC
) (
  input wire mclk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire st_running,
  input wire st_fault_stop,
  input wire st_out_freq_zero,
  input wire st_motor_ol_prealarm,
  input wire st_drive_ol_prealarm,
  input wire st_set_count_hit,
  input wire st_desig_count_hit,
  input wire st_length_hit,
  input wire st_seq_cycle_done,
  input wire st_run_time_hit,
  input wire st_cmd_beyond_limit,
  input wire st_at_limit,
  input wire st_speed_mode,
  input wire st_torque_at_limit,
  input wire st_stall_active,
  input wire st_supplies_ok,
  input wire st_operable,
  input wire [15:0] analog_input_first,
  input wire [15:0] analog_input_second,
  input wire st_at_upper,
  input wire st_at_lower,
  input wire st_undervoltage,
  input wire st_power_on_hit,
  input wire freq_level_detect_first,
  input wire freq_level_detect_second,
  input wire st_freq_reached,
  input wire comm_out_request,
  output reg open_collector_out_1,
  output reg main_relay_contacts,
  output reg second_relay_out,
  output reg multiplexed_switch_out
);

  reg [15:0] oc_sel_q;
  reg [15:0] rly1_sel_q;
  reg [15:0] rly2_sel_q;
  reg [15:0] swm_sel_q;
  reg mode_q;
  reg [31:0] pulse_cnt_q;
  reg seq_pulse;
  reg [31:0] rd_d;
  reg map_hit;
  reg [31:0] cond;
  wire wr_en;
  wire oc_on;
  wire r1_on;
  wire r2_on;
  wire sw_on;

  assign wr_en = psel & penable & pwrite & pready;

  // Selector and mode registers
  always @(posedge mclk) begin
    if (rst) begin
      oc_sel_q <= `OTFM_RST_OC_SEL; // [RULE_22]
      rly1_sel_q <= `OTFM_RST_RLY1_SEL; // [RULE_22]
      rly2_sel_q <= `OTFM_RST_RLY2_SEL; // [RULE_22]
      swm_sel_q <= `OTFM_RST_SWM_SEL; // [RULE_22]
      mode_q <= `OTFM_RST_MODE;
    end else if (wr_en) begin
      case (paddr)
        `OTFM_ADDR_OC_SEL: oc_sel_q <= pwdata[15:0];
        `OTFM_ADDR_RLY1_SEL: rly1_sel_q <= pwdata[15:0];
        `OTFM_ADDR_RLY2_SEL: rly2_sel_q <= pwdata[15:0];
        `OTFM_ADDR_SWM_SEL: swm_sel_q <= pwdata[15:0];
        `OTFM_ADDR_MODE: mode_q <= pwdata[0];
        default: ;
      endcase
    end
  end

  // Read decode
  always @* begin
    rd_d = 32'h0000_0000;
    map_hit = 1'b1;
    case (paddr)
      `OTFM_ADDR_OC_SEL: rd_d = {16'h0000, oc_sel_q};
      `OTFM_ADDR_RLY1_SEL: rd_d = {16'h0000, rly1_sel_q};
      `OTFM_ADDR_RLY2_SEL: rd_d = {16'h0000, rly2_sel_q};
      `OTFM_ADDR_RSVD_SEL: rd_d = 32'h0000_0000;
      `OTFM_ADDR_SWM_SEL: rd_d = {16'h0000, swm_sel_q};
      `OTFM_ADDR_MODE: rd_d = {31'h0000_0000, mode_q};
      `OTFM_ADDR_STATUS: rd_d = {27'h0000_000, seq_pulse,
        multiplexed_switch_out, second_relay_out,
        main_relay_contacts, open_collector_out_1};
      default: map_hit = 1'b0;
    endcase
  end

  // APB slave: one wait state, answer on second access cycle
  always @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~map_hit;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rd_d;
    end
  end

  // Sequencer cycle pulse, retriggered by each completion
  always @(posedge mclk) begin
    if (rst) begin
      pulse_cnt_q <= 32'h0000_0000;
      seq_pulse <= 1'b0;
    end else if (st_seq_cycle_done) begin
      pulse_cnt_q <= PULSE_CYC - 1; // [RULE_11]
      seq_pulse <= 1'b1;
    end else if (pulse_cnt_q != 32'h0000_0000) begin
      pulse_cnt_q <= pulse_cnt_q - 32'h0000_0001;
    end else begin
      seq_pulse <= 1'b0; // [RULE_11]
    end
  end

  // Shared function table, one bit per code
  always @* begin
    cond = 32'h0000_0000;
    cond[`OTFM_FN_RUN] = st_running; // [RULE_03]
    cond[`OTFM_FN_FAULT] = st_fault_stop; // [RULE_04]
    cond[`OTFM_FN_FLD1] = freq_level_detect_first; // [RULE_25]
    cond[`OTFM_FN_FREACH] = st_freq_reached; // [RULE_25]
    cond[`OTFM_FN_ZSPD] = st_running & st_out_freq_zero; // [RULE_05]
    cond[`OTFM_FN_MOL] = st_motor_ol_prealarm; // [RULE_06]
    cond[`OTFM_FN_DOL] = st_drive_ol_prealarm; // [RULE_07]
    cond[`OTFM_FN_SETCNT] = st_set_count_hit; // [RULE_08]
    cond[`OTFM_FN_DESCNT] = st_desig_count_hit; // [RULE_09]
    cond[`OTFM_FN_LEN] = st_length_hit; // [RULE_10]
    cond[`OTFM_FN_SEQ] = seq_pulse; // [RULE_11]
    cond[`OTFM_FN_RUNT] = st_run_time_hit; // [RULE_12]
    cond[`OTFM_FN_FLIM] = st_cmd_beyond_limit & st_at_limit; // [RULE_13]
    cond[`OTFM_FN_TLIM] = st_speed_mode & st_torque_at_limit &
      st_stall_active; // [RULE_14]
    cond[`OTFM_FN_READY] = st_supplies_ok & ~st_fault_stop &
      st_operable; // [RULE_15]
    cond[`OTFM_FN_AIN] = analog_input_first >
      analog_input_second; // [RULE_16]
    cond[`OTFM_FN_UPPER] = st_at_upper; // [RULE_17]
    cond[`OTFM_FN_LOWER] = st_at_lower & st_running; // [RULE_18]
    cond[`OTFM_FN_UV] = st_undervoltage; // [RULE_19]
    cond[`OTFM_FN_COMM] = comm_out_request; // [RULE_25]
    cond[`OTFM_FN_ZSPD2] = st_out_freq_zero | ~st_running; // [RULE_20]
    cond[`OTFM_FN_PONT] = st_power_on_hit; // [RULE_21]
    cond[`OTFM_FN_FLD2] = freq_level_detect_second; // [RULE_25]
  end

  // Per-terminal selection; codes above 31 are off
  assign oc_on = (oc_sel_q[15:5] == 11'h000) & cond[oc_sel_q[4:0]]; // [RULE_01]
  assign r1_on = (rly1_sel_q[15:5] == 11'h000) & cond[rly1_sel_q[4:0]];
  assign r2_on = (rly2_sel_q[15:5] == 11'h000) & cond[rly2_sel_q[4:0]];
  assign sw_on = (swm_sel_q[15:5] == 11'h000) & cond[swm_sel_q[4:0]];

  // Terminal outputs, refreshed every clock; bit 0 of cond stays low
  always @(posedge mclk) begin
    if (rst) begin
      open_collector_out_1 <= 1'b0;
      main_relay_contacts <= 1'b0;
      second_relay_out <= 1'b0;
      multiplexed_switch_out <= 1'b0;
    end else begin
      open_collector_out_1 <= oc_on; // [RULE_24] [RULE_02]
      main_relay_contacts <= r1_on; // [RULE_24]
      second_relay_out <= r2_on; // [RULE_24]
      multiplexed_switch_out <= sw_on &
        (mode_q == `OTFM_MODE_SWITCH); // [RULE_23]
    end
  end

endmodule // otfm_top
`default_nettype wire

// ### hw/otfm_regs.vh
`ifndef OTFM_REGS_VH
`define OTFM_REGS_VH
// Register byte addresses
`define OTFM_ADDR_OC_SEL 12'h000
`define OTFM_ADDR_RLY1_SEL 12'h004
`define OTFM_ADDR_RLY2_SEL 12'h008
`define OTFM_ADDR_RSVD_SEL 12'h00C
`define OTFM_ADDR_SWM_SEL 12'h010
`define OTFM_ADDR_MODE 12'h014
`define OTFM_ADDR_STATUS 12'h018
// Reset values
`define OTFM_RST_OC_SEL 16'h0001
`define OTFM_RST_RLY1_SEL 16'h0002
`define OTFM_RST_RLY2_SEL 16'h0000
`define OTFM_RST_SWM_SEL 16'h0000
`define OTFM_RST_MODE 1'b0
// Mode field: 0 pulse, 1 switch
`define OTFM_MODE_SWITCH 1'b1
// Function codes
`define OTFM_FN_NONE 5'd0
`define OTFM_FN_RUN 5'd1
`define OTFM_FN_FAULT 5'd2
`define OTFM_FN_FLD1 5'd3
`define OTFM_FN_FREACH 5'd4
`define OTFM_FN_ZSPD 5'd5
`define OTFM_FN_MOL 5'd6
`define OTFM_FN_DOL 5'd7
`define OTFM_FN_SETCNT 5'd8
`define OTFM_FN_DESCNT 5'd9
`define OTFM_FN_LEN 5'd10
`define OTFM_FN_SEQ 5'd11
`define OTFM_FN_RUNT 5'd12
`define OTFM_FN_FLIM 5'd13
`define OTFM_FN_TLIM 5'd14
`define OTFM_FN_READY 5'd15
`define OTFM_FN_AIN 5'd16
`define OTFM_FN_UPPER 5'd17
`define OTFM_FN_LOWER 5'd18
`define OTFM_FN_UV 5'd19
`define OTFM_FN_COMM 5'd20
`define OTFM_FN_ZSPD2 5'd23
`define OTFM_FN_PONT 5'd24
`define OTFM_FN_FLD2 5'd25
// Sequencer pulse width
`define OTFM_PULSE_MS 250
`define OTFM_CLK_HZ 40000000
`define OTFM_PULSE_CYC (`OTFM_PULSE_MS * (`OTFM_CLK_HZ / 1000))
`endif

// ### tb/otfm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module otfm_properties (
  input wire logic mclk, rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic st_running, st_fault_stop, open_collector_out_1,
  input wire logic [15:0] analog_input_first, analog_input_second
);
  logic [15:0] sel_q;
  logic [4:0] code_q;
  logic gt_q;
  wire wr = psel && penable && pready && pwrite && paddr == 12'h000;
  // Shadow of the open-collector selector, code 31 while it settles
  always @(posedge mclk) begin
    if (rst)
      sel_q <= 16'h0001;
    else if (wr)
      sel_q <= pwdata[15:0];
    code_q <= (rst || wr) ? 5'h1f : sel_q[4:0];
    gt_q <= analog_input_first > analog_input_second;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  reset_clear_a: assert property (
    disable iff (1'b0) rst |=> !open_collector_out_1)
    else $error("output set after reset");
  oc_off_a: assert property (
    code_q == 5'h00 |-> !open_collector_out_1)
    else $error("code 0 output on");
  oc_run_a: assert property (
    code_q == 5'h01 |-> open_collector_out_1 == $past(st_running))
    else $error("run code mismatch");
  oc_fault_a: assert property (
    code_q == 5'h02 |-> open_collector_out_1 == $past(st_fault_stop))
    else $error("fault code mismatch");
  oc_analog_a: assert property (
    code_q == 5'h10 |-> open_collector_out_1 == gt_q)
    else $error("analog code mismatch");
endmodule // otfm_properties
bind otfm_top otfm_properties u_chk (.*);
`default_nettype wire

// ### tb/otfm_load.sv
`timescale 1ns/1ps
`default_nettype none
module otfm_load (
  input wire logic mclk,
  input wire logic [3:0] drive,
  output logic [3:0] coil_q
);
  // Relay coils pick up the terminal levels one clock later
  always @(posedge mclk) coil_q <= drive;
endmodule // otfm_load
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "otfm_regs.vh"
module tb;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [24:0] st;
  logic [15:0] analog_input_first, analog_input_second;
  wire [3:0] outs;
  wire [3:0] coil;
  int bad_count, samples_checked, n;
  byte cd[15] = '{1, 6, 7, 8, 2, 9, 10, 12, 17, 19, 24, 3, 25, 4, 20};
  byte bt[15] = '{0, 3, 4, 5, 1, 6, 7, 9, 17, 19, 20, 21, 22, 23, 24};
  otfm_top #(.PULSE_CYC(8)) u_dut (.*, .st_running(st[0]),
    .st_fault_stop(st[1]), .st_out_freq_zero(st[2]),
    .st_motor_ol_prealarm(st[3]), .st_drive_ol_prealarm(st[4]),
    .st_set_count_hit(st[5]), .st_desig_count_hit(st[6]),
    .st_length_hit(st[7]), .st_seq_cycle_done(st[8]),
    .st_run_time_hit(st[9]), .st_cmd_beyond_limit(st[10]),
    .st_at_limit(st[11]), .st_speed_mode(st[12]),
    .st_torque_at_limit(st[13]), .st_stall_active(st[14]),
    .st_supplies_ok(st[15]), .st_operable(st[16]), .st_at_upper(st[17]),
    .st_at_lower(st[18]), .st_undervoltage(st[19]),
    .st_power_on_hit(st[20]), .freq_level_detect_first(st[21]),
    .freq_level_detect_second(st[22]), .st_freq_reached(st[23]),
    .comm_out_request(st[24]), .open_collector_out_1(outs[0]),
    .main_relay_contacts(outs[1]), .second_relay_out(outs[2]),
    .multiplexed_switch_out(outs[3]));
  otfm_load u_load (.mclk(mclk), .drive(outs), .coil_q(coil));
  // Clock and time-zero input levels
  initial begin
    {mclk, rst, psel, penable, pwrite} = 5'h08;
    {paddr, pwdata, st} = 69'h0;
    {analog_input_first, analog_input_second} = 32'h0000_0000;
    forever #12.5 mclk = ~mclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One APB transfer; waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      conclude;
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge mclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, x);
  endtask
  task sel(input int t, input int c);
    apb(1'b1, t == 3 ? `OTFM_ADDR_SWM_SEL : 12'(4 * t), 32'(c));
  endtask
  // Own terminal follows the code, the others stay off
  task tc(input int t, input int c, input logic [24:0] m, input logic x);
    st <= m;
    sel(t, c);
    repeat (4) @(posedge mclk);
    chk(32'(coil), 32'(x) << t);
    sel(t, 0);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(`OTFM_ADDR_OC_SEL, 32'h0000_0001);
    rd(`OTFM_ADDR_RLY1_SEL, 32'h0000_0002);
    rd(`OTFM_ADDR_RLY2_SEL, 32'h0000_0000);
    rd(`OTFM_ADDR_SWM_SEL, 32'h0000_0000);
    apb(1'b1, `OTFM_ADDR_RSVD_SEL, 32'h0000_0005);
    rd(`OTFM_ADDR_RSVD_SEL, 32'h0000_0000);
    rd(12'h020, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    sel(0, 0);
    sel(1, 0);
    $display("registers done");
    tc(3, 1, 25'h000_0001, 1'b0);
    apb(1'b1, `OTFM_ADDR_MODE, 32'h0000_0001);
    tc(3, 1, 25'h000_0001, 1'b1);
    for (n = 0; n < 15; n++) begin
      tc(n % 4, cd[n], 25'h000_0001 << bt[n], 1'b1);
      tc(n % 4, cd[n], 25'h000_0000, 1'b0);
    end
    tc(0, 5, 25'h000_0005, 1'b1);
    tc(1, 5, 25'h000_0004, 1'b0);
    tc(2, 18, 25'h004_0000, 1'b0);
    tc(3, 18, 25'h004_0001, 1'b1);
    tc(0, 23, 25'h000_0000, 1'b1);
    tc(1, 23, 25'h000_0001, 1'b0);
    tc(2, 13, 25'h000_0800, 1'b0);
    tc(3, 13, 25'h000_0c00, 1'b1);
    tc(0, 14, 25'h000_6000, 1'b0);
    tc(1, 14, 25'h000_7000, 1'b1);
    tc(2, 15, 25'h001_8002, 1'b0);
    tc(3, 15, 25'h001_8000, 1'b1);
    tc(0, 21, 25'h1ff_ffff, 1'b0);
    $display("code table done");
    st <= 25'h000_0000;
    sel(0, 11);
    repeat (12) @(posedge mclk);
    st <= 25'h000_0100;
    @(posedge mclk);
    st <= 25'h000_0000;
    n = 0;
    repeat (20) @(posedge mclk) n += coil[0];
    chk(32'(n), 32'h0000_0008);
    sel(0, 16);
    analog_input_first <= 16'h0005;
    analog_input_second <= 16'h0005;
    repeat (4) @(posedge mclk);
    chk(32'(coil), 32'h0000_0000);
    analog_input_first <= 16'h0006;
    repeat (4) @(posedge mclk);
    chk(32'(coil), 32'h0000_0001);
    rd(`OTFM_ADDR_STATUS, 32'h0000_0001);
    rd(`OTFM_ADDR_MODE, 32'h0000_0001);
    $display("pulse and analog done");
    conclude;
  end
endmodule // tb
`default_nettype wire
